// ===== rtl/chop_detect_pkg.sv
package chop_detect_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'h06;
  localparam logic [7:0] THR_UPPER_ADDR = 8'h07;
  localparam logic [7:0] THR_LOWER_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h11;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h0600;
  localparam logic [15:0] THR_UPPER_RESET = 16'h0000;
  localparam logic [7:0] THR_LOWER_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [15:0] READ_NONE = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions of the configuration word and of the low threshold byte
  // ----------------------------------------------------------------
  localparam int DLY_MSB = 12;
  localparam int DLY_LSB = 9;
  localparam int CHOP_EN_BIT = 8;
  localparam int ALLCH_BIT = 7;
  localparam int NUM_MSB = 6;
  localparam int NUM_LSB = 4;
  localparam int LEN_MSB = 3;
  localparam int LEN_LSB = 1;
  localparam int DET_EN_BIT = 0;
  localparam int LOW_MSB = 15;
  localparam int LOW_LSB = 8;

  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_DETECT_BIT = 0;
  localparam int IRQ_WINDOW_BIT = 1;

  // ----------------------------------------------------------------
  // Datapath sizes and count tables
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int SAMPLE_W = 24;
  localparam int LEN_W = 12;
  localparam int SETTLE_W = 17;
  localparam logic [11:0] LEN_0 = 12'h080;
  localparam logic [11:0] LEN_1 = 12'h100;
  localparam logic [11:0] LEN_2 = 12'h200;
  localparam logic [11:0] LEN_3 = 12'h300;
  localparam logic [11:0] LEN_4 = 12'h500;
  localparam logic [11:0] LEN_5 = 12'h700;
  localparam logic [11:0] LEN_6 = 12'hA00;
  localparam logic [11:0] LEN_7 = 12'hE00;

  // Chop sequencer, Gray coded along idle, settle, measure
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_MEASURE = 2'b11
  } chop_state_t;

endpackage

// ===== rtl/threshold_compare.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Signed sample against signed threshold
// ------------------------------------------------------------------
module threshold_compare #(
  parameter int WIDTH = 24
) (
  // Operands
  input wire logic signed [WIDTH-1:0] sample,
  input wire logic signed [WIDTH-1:0] threshold,
  // Result
  output logic exceed
);

  // Strictly above; equal does not count as exceeding
  assign exceed = (sample > threshold);

endmodule

`default_nettype wire

// ===== rtl/chop_detect_config.sv
// Contract
// - Chop settle wait is two to code plus one
// - Configuration bit 8 enables global chop
// - Bit 7 selects any or all channels
// - Exceedances needed are two to bits 6:4
// - Bits 3:1 pick the window length
// - Threshold is signed 24-bit two's complement
// - Upper threshold word at 07h, resets zero
// - Low threshold byte in 08h upper byte
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module chop_detect_config (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [15:0] rdata,
  // Modulator side
  input wire logic modTick,
  input wire logic chopSwap,
  input wire logic convValid,
  input wire logic [5:0][23:0] chanData,
  // Status to the converter
  output logic chopEnable,
  output logic measureGate,
  output logic currentDetect,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] chopDetectConfiguration;
  logic [15:0] detectThresholdUpper;
  logic [7:0] detectThresholdLowBits;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;

  // Address decode
  wire logic hitCfg = (addr == chop_detect_pkg::CFG_ADDR);
  wire logic hitUpper = (addr == chop_detect_pkg::THR_UPPER_ADDR);
  wire logic hitLower = (addr == chop_detect_pkg::THR_LOWER_ADDR);
  wire logic hitStatus = (addr == chop_detect_pkg::IRQ_STATUS_ADDR);
  wire logic hitMask = (addr == chop_detect_pkg::IRQ_MASK_ADDR);
  wire logic wrCfg = wrStrobe && hitCfg;
  wire logic wrUpper = wrStrobe && hitUpper;
  wire logic wrLower = wrStrobe && hitLower;
  wire logic wrStatus = wrStrobe && hitStatus;
  wire logic wrMask = wrStrobe && hitMask;

  // Field views of the configuration word
  wire logic [3:0] chopSettleDelayCode =
    chopDetectConfiguration[chop_detect_pkg::DLY_MSB:
                            chop_detect_pkg::DLY_LSB];
  wire logic detectRequireEveryChannel =
    chopDetectConfiguration[chop_detect_pkg::ALLCH_BIT];
  wire logic [2:0] detectExceedCount =
    chopDetectConfiguration[chop_detect_pkg::NUM_MSB:
                            chop_detect_pkg::NUM_LSB];
  wire logic [2:0] detectWindowLength =
    chopDetectConfiguration[chop_detect_pkg::LEN_MSB:
                            chop_detect_pkg::LEN_LSB];
  wire logic detectModeEnable =
    chopDetectConfiguration[chop_detect_pkg::DET_EN_BIT];

  // Enable is the stored bit itself, so it follows a write at once
  assign chopEnable =
    chopDetectConfiguration[chop_detect_pkg::CHOP_EN_BIT];

  // Configuration and threshold registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chopDetectConfiguration <= chop_detect_pkg::CFG_RESET;
      detectThresholdUpper <= chop_detect_pkg::THR_UPPER_RESET;
      detectThresholdLowBits <= chop_detect_pkg::THR_LOWER_RESET;
      irqMask <= chop_detect_pkg::IRQ_RESET;
    end else begin
      if (wrCfg) chopDetectConfiguration <= wdata;
      if (wrUpper) detectThresholdUpper <= wdata;
      if (wrLower) detectThresholdLowBits <= wdata[15:8];
      if (wrMask) irqMask <= wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Threshold and channel comparison
  // ----------------------------------------------------------------
  // Upper word supplies bits 23:8, low byte bits 7:0
  wire logic signed [23:0] detectThreshold =
    {detectThresholdUpper, detectThresholdLowBits};
  logic [5:0] chanExceed;

  genvar ch;
  generate
    for (ch = 0; ch < chop_detect_pkg::NUM_CH; ch++) begin : g_cmp
      threshold_compare #(
        .WIDTH(chop_detect_pkg::SAMPLE_W)
      ) u_cmp (
        .sample(chanData[ch]),
        .threshold(detectThreshold),
        .exceed(chanExceed[ch])
      );
    end
  endgenerate

  // Any channel, or every channel when qualified
  wire logic sampleHit = detectRequireEveryChannel ?
    (&chanExceed) : (|chanExceed);

  // ----------------------------------------------------------------
  // Global-chop settle sequencer
  // ----------------------------------------------------------------
  chop_detect_pkg::chop_state_t chopState;
  chop_detect_pkg::chop_state_t next_chopState;
  logic [16:0] settleCount;
  logic [16:0] next_settleCount;

  // Wait of 2^(code+1) modulator periods; code 15 needs all 17 bits
  wire logic [16:0] settleLoad =
    17'(17'h00001 << (5'(chopSettleDelayCode) + 5'h01));
  wire logic settleLast = modTick && (settleCount == 17'h00001);

  // Next state; a chop swap restarts the wait only while chop is enabled
  always_comb begin
    next_chopState = chopState;
    next_settleCount = settleCount;
    case (chopState)
      chop_detect_pkg::ST_IDLE: begin
        if (chopEnable) begin
          next_chopState = chop_detect_pkg::ST_SETTLE;
          next_settleCount = settleLoad;
        end else begin
          next_chopState = chop_detect_pkg::ST_MEASURE;
        end
      end
      chop_detect_pkg::ST_SETTLE: begin
        if (!chopEnable) begin
          next_chopState = chop_detect_pkg::ST_MEASURE;
        end else if (chopSwap) begin
          next_settleCount = settleLoad;
        end else if (settleLast) begin
          next_chopState = chop_detect_pkg::ST_MEASURE;
        end else if (modTick) begin
          next_settleCount = settleCount - 17'h00001;
        end
      end
      chop_detect_pkg::ST_MEASURE: begin
        if (chopEnable && chopSwap) begin
          next_chopState = chop_detect_pkg::ST_SETTLE;
          next_settleCount = settleLoad;
        end
      end
      default: begin
        next_chopState = chop_detect_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chopState <= chop_detect_pkg::ST_IDLE;
      settleCount <= 17'h00000;
    end else begin
      chopState <= next_chopState;
      settleCount <= next_settleCount;
    end
  end

  assign measureGate = (chopState == chop_detect_pkg::ST_MEASURE);

  // ----------------------------------------------------------------
  // Current-detect window
  // ----------------------------------------------------------------
  logic [11:0] periodCount;
  logic [11:0] hitCount;
  logic [11:0] windowLen;

  // Window length in conversion periods
  always_comb begin
    case (detectWindowLength)
      3'h0: windowLen = chop_detect_pkg::LEN_0;
      3'h1: windowLen = chop_detect_pkg::LEN_1;
      3'h2: windowLen = chop_detect_pkg::LEN_2;
      3'h3: windowLen = chop_detect_pkg::LEN_3;
      3'h4: windowLen = chop_detect_pkg::LEN_4;
      3'h5: windowLen = chop_detect_pkg::LEN_5;
      3'h6: windowLen = chop_detect_pkg::LEN_6;
      3'h7: windowLen = chop_detect_pkg::LEN_7;
      default: windowLen = chop_detect_pkg::LEN_0;
    endcase
  end

  // Conversions during chop settling are not trusted, so skipped
  wire logic sampleAccept = detectModeEnable && convValid && measureGate;
  wire logic [11:0] hitTotal = hitCount + {11'h000, sampleHit};
  wire logic [11:0] hitsNeeded = 12'(12'h001 << detectExceedCount);
  wire logic windowEnd =
    sampleAccept && (periodCount == windowLen - 12'h001);
  wire logic detectNow = windowEnd && (hitTotal >= hitsNeeded);

  // Counters cleared whenever the mode is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periodCount <= 12'h000;
      hitCount <= 12'h000;
      currentDetect <= 1'b0;
    end else begin
      currentDetect <= detectNow;
      if (!detectModeEnable || windowEnd) begin
        periodCount <= 12'h000;
        hitCount <= 12'h000;
      end else if (sampleAccept) begin
        periodCount <= periodCount + 12'h001;
        hitCount <= hitTotal;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and read-back
  // ----------------------------------------------------------------
  // A new event wins over a write-one-to-clear in the same cycle
  wire logic [1:0] irqEvent = {windowEnd, detectNow};
  wire logic [1:0] irqClear = wrStatus ? wdata[1:0] : 2'h0;
  wire logic [1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvent;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) irqStatus <= chop_detect_pkg::IRQ_RESET;
    else irqStatus <= next_irqStatus;
  end

  assign irq = |(irqStatus & irqMask);

  // Read mux; unmapped addresses read zero
  wire logic [15:0] readValue =
    hitCfg ? chopDetectConfiguration :
    hitUpper ? detectThresholdUpper :
    hitLower ? {detectThresholdLowBits, 8'h00} :
    hitStatus ? {14'h0000, irqStatus} :
    hitMask ? {14'h0000, irqMask} : chop_detect_pkg::READ_NONE;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rdata <= chop_detect_pkg::READ_NONE;
    else rdata <= rdStrobe ? readValue : chop_detect_pkg::READ_NONE;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence swapWhileChopping;
    chopEnable && chopSwap;
  endsequence

  sequence settleLoaded;
    chopState == chop_detect_pkg::ST_SETTLE &&
      settleCount == 17'(17'h00001 << ($past(chopSettleDelayCode) + 1));
  endsequence

  chop_wait_load_a: assert property (
    swapWhileChopping |=> settleLoaded)
    else $error("settle count not loaded from delay code");

  chop_off_gate_a: assert property (
    !chopEnable && !$past(chopEnable) |-> ##1 measureGate)
    else $error("measurement gated while chop is off");

  // Qualifier taken at the sample edge, a write there may change it
  hit_count_a: assert property (
    sampleAccept && !windowEnd && detectModeEnable |=>
      hitCount == $past(hitCount) + 12'($past(detectRequireEveryChannel) ?
        &$past(chanExceed) : |$past(chanExceed)))
    else $error("hit count does not follow channel qualification");

  detect_need_a: assert property (
    windowEnd |=> currentDetect ==
      ($past(hitTotal) >= 12'(1 << $past(detectExceedCount))))
    else $error("detection does not match required exceedances");

  window_len_a: assert property (
    windowEnd |-> periodCount + 12'h001 == windowLen)
    else $error("window ended at wrong length");

  mode_off_a: assert property (
    !detectModeEnable |=> periodCount == 12'h000 && !currentDetect)
    else $error("detect logic active while mode disabled");

  thresh_join_a: assert property (
    detectThreshold[23:8] == detectThresholdUpper &&
      detectThreshold[7:0] == detectThresholdLowBits)
    else $error("threshold assembled wrongly");

  upper_write_a: assert property (
    wrUpper |=> detectThresholdUpper == $past(wdata))
    else $error("upper threshold word not stored");

  upper_read_a: assert property (
    rdStrobe && hitUpper |=> rdata == $past(detectThresholdUpper))
    else $error("upper threshold read-back wrong");

  lower_write_a: assert property (
    wrLower |=> detectThresholdLowBits == $past(wdata[15:8]))
    else $error("low threshold byte not stored");

  // A clear in the event cycle must not lose the event
  event_wins_a: assert property (
    irqEvent != 2'h0 |=> (irqStatus & $past(irqEvent)) == $past(irqEvent))
    else $error("status event lost to a clear");

  irq_level_a: assert property (
    ##1 irq == |($past(next_irqStatus) & irqMask))
    else $error("interrupt level disagrees with status");

endmodule

`default_nettype wire

// ===== testbench/host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------
// Register host
// ----------------
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  input wire logic [15:0] rdata,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wrStrobe,
  output logic rdStrobe
);
  // Idle bus at time zero
  initial begin
    addr <= 8'hFF;
    wdata <= 16'h0000;
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
  end

  // Released lines show inverted values, never the last word
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule

`default_nettype wire

// ===== testbench/chop_and_current_detect_config_tb.sv
`timescale 1ns/10ps
`default_nettype none

module chop_and_current_detect_config_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic modTick = 1'b0;
  logic chopSwap = 1'b0;
  logic convValid = 1'b0;
  logic [5:0][23:0] chanData = '0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wrStrobe;
  logic rdStrobe;
  logic [15:0] rdata;
  logic chopEnable;
  logic measureGate;
  logic currentDetect;
  logic irq;
  int fail_count = 0;
  int checks_done = 0;
  int detCount = 0;
  int cycles = 0;
  logic [15:0] rv;
  int lens[8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};

  always #10 clk = ~clk;

  chop_detect_config chop_detect_config_inst (.clk, .rst_b, .addr,
    .wdata, .wrStrobe, .rdStrobe, .rdata, .modTick, .chopSwap,
    .convValid, .chanData, .chopEnable, .measureGate, .currentDetect,
    .irq);
  host_model host_model_inst (.clk, .rdata, .addr, .wdata, .wrStrobe,
    .rdStrobe);

  // Pulse tally; the 40000-cycle ceiling sits about 2.7 times the expected run of some 14600 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (currentDetect === 1'b1)
      detCount <= detCount + 1;
    if (cycles == 40000) begin
      fail_count++;
      close_out;
    end
  end

  // ----------------
  // Common tasks
  // ----------------
  task automatic close_out;
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    host_model_inst.rd(a, rv);
    cmp16(rv, e);
  endtask

  task automatic thr(input logic [15:0] hi, input logic [15:0] lo);
    host_model_inst.wr(8'h07, hi);
    host_model_inst.wr(8'h08, lo);
  endtask

  function automatic logic [143:0] fill(input logic [23:0] v);
    return {6{v}};
  endfunction

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    rchk(8'h06, 16'h0600);
    rchk(8'h07, 16'h0000);
    rchk(8'h08, 16'h0000);
    rchk(8'h20, 16'h0000);
    cmp1(chopEnable, 1'b0);
    cmp1(measureGate, 1'b1);
    cmp1(currentDetect, 1'b0);
    cmp1(irq, 1'b0);
  endtask

  task automatic t_regs;
    thr(16'hA5C3, 16'h5A77);
    rchk(8'h07, 16'hA5C3);
    rchk(8'h08, 16'h5A00);
  endtask

  // Gate falls on the swap, rises after the last of 2^(code+1) ticks
  task automatic t_chop(input logic [3:0] code);
    int n;
    n = 2 ** (code + 1);
    host_model_inst.wr(8'h06, {3'h0, code, 9'h100});
    cmp1(chopEnable, 1'b1);
    @(posedge clk) chopSwap <= 1'b1;
    @(posedge clk) chopSwap <= 1'b0;
    #1 cmp1(measureGate, 1'b0);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) modTick <= 1'b1;
      #1;
      if (i == n - 1) cmp1(measureGate, 1'b0);
    end
    @(posedge clk) modTick <= 1'b0;
    #1 cmp1(measureGate, 1'b1);
  endtask

  task automatic t_chop_off;
    host_model_inst.wr(8'h06, 16'h0600);
    @(posedge clk) chopSwap <= 1'b1;
    @(posedge clk) chopSwap <= 1'b0;
    #1 cmp1(measureGate, 1'b1);
    cmp1(chopEnable, 1'b0);
  endtask

  // One full window: k hit samples first, then misses
  task automatic t_win(input logic [15:0] cfg, input int k,
      input logic [143:0] hit, input logic [143:0] miss, input logic exp);
    int n;
    int base;
    n = lens[cfg[3:1]];
    host_model_inst.wr(8'h06, 16'h0600);
    host_model_inst.wr(8'h06, cfg);
    host_model_inst.wr(8'h10, 16'h0003);
    base = detCount;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) convValid <= 1'b1;
      chanData <= (i < k) ? hit : miss;
    end
    @(posedge clk) convValid <= 1'b0;
    chanData <= ~miss;
    #1 cmp1(currentDetect, exp);
    @(posedge clk);
    #1 cmp16(16'(detCount - base), {15'h0, exp});
    rchk(8'h10, {14'h0, cfg[0], exp});
  endtask

  task automatic t_detect;
    logic [143:0] h;
    logic [143:0] m;
    h = fill(24'h000001);
    m = fill(24'h000000);
    thr(16'h0000, 16'h0000);
    for (int c = 0; c < 8; c++)
      t_win({9'h006, 3'h0, 3'(c), 1'b1}, 1, h, m, 1'b1);
    for (int c = 0; c < 8; c++) begin
      t_win({9'h006, 3'(c), 4'h1}, 2 ** c - 1, h, m, 1'b0);
      t_win({9'h006, 3'(c), 4'h1}, 2 ** c, h, m, 1'b1);
    end
    t_win(16'h0681, 128, {24'h0, {5{24'h1}}}, m, 1'b0);
    t_win(16'h0681, 1, h, m, 1'b1);
    t_win(16'h0601, 1, {24'h1, {5{24'h0}}}, m, 1'b1);
    t_win(16'h0600, 128, h, m, 1'b0);
    thr(16'hFFFF, 16'hFF00);
    t_win(16'h0601, 1, m, fill(24'hFFFFFF), 1'b1);
    thr(16'h0000, 16'h0500);
    t_win(16'h0601, 1, fill(24'h000006), fill(24'h000005), 1'b1);
    thr(16'h0001, 16'h0000);
    t_win(16'h0601, 1, fill(24'h000101), fill(24'h000100), 1'b1);
    thr(16'h7FFF, 16'h0000);
    t_win(16'h0601, 0, m, fill(24'h800000), 1'b0);
  endtask

  // Reset in mid-run: outputs drop at once, gate opens one edge later
  task automatic t_rerst;
    host_model_inst.wr(8'h07, 16'h1234);
    host_model_inst.wr(8'h06, 16'h1F01);
    host_model_inst.wr(8'h11, 16'h0003);
    cmp1(irq, 1'b1);
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    #1 cmp1(measureGate, 1'b0);
    cmp16(rdata, 16'h0000);
    cmp1(irq, 1'b0);
    @(posedge clk);
    #1 cmp1(measureGate, 1'b1);
    rchk(8'h07, 16'h0000);
    rchk(8'h06, 16'h0600);
    rchk(8'h10, 16'h0000);
    rchk(8'h11, 16'h0000);
  endtask

  // Sticky status under the mask, write one to clear
  task automatic t_irq;
    thr(16'h0000, 16'h0000);
    t_win(16'h0601, 1, fill(24'h000001), fill(24'h000000), 1'b1);
    cmp1(irq, 1'b0);
    host_model_inst.wr(8'h11, 16'h0001);
    cmp1(irq, 1'b1);
    rchk(8'h11, 16'h0001);
    host_model_inst.wr(8'h10, 16'h0001);
    cmp1(irq, 1'b0);
    rchk(8'h10, 16'h0002);
    host_model_inst.wr(8'h11, 16'h0003);
    cmp1(irq, 1'b1);
    host_model_inst.wr(8'h10, 16'h0002);
    cmp1(irq, 1'b0);
    rchk(8'h10, 16'h0000);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_regs;
    for (int c = 0; c < 5; c++)
      t_chop(4'(c));
    t_chop_off;
    t_detect;
    t_rerst;
    t_irq;
    close_out;
  end
endmodule

`default_nettype wire
